// file: design/rgc_pkg.sv
// Package of register map, field layout, timing and carrier types
// Functional notes
// - Auto switch off: forced bit6 picks PULSE_FREQUENCY_MODULATION/PWM
// - Override forces linear; else bit7 selects
// - Linear6 voltage 0.7V plus 25mV steps, saturating
// - Buck trip: 0 gives +10%, 1 +20%
// - Linear1 trip codes: +7, +11, +15, +20%
// - Other linear trips: +5, +10, +15, +20%
// - Overvoltage qualified after 1ms; interrupt if enabled
// - Load switch: linear or switch, 3.0-3.3V
// - Bias big/small; soft start slow/fast
// - Buck3 pull-down only on later silicon
// - Detect level codes; fixed level per converter
// - PULSE_FREQUENCY_MODULATION current limit: smaller or bigger
// - Auto PWM-to-PULSE_FREQUENCY_MODULATION peak threshold small/big
// - Current detect enable resets to one
// - Switched supply low-voltage protect, bit12, reset one
// - Clear bit wipes flags 15:4, self-returns
package rgc_pkg;

	// ***************************************************
	// Register offsets and reset values
	// ***************************************************
	localparam logic [7:0] ADDR_BUCK2 = 8'h14;
	localparam logic [7:0] ADDR_BUCK3 = 8'h17;
	localparam logic [5:0][7:0] ADDR_LINEAR =
		{8'h24, 8'h23, 8'h22, 8'h20, 8'h1f, 8'h1e};
	localparam logic [7:0] ADDR_SWITCHED = 8'h28;
	localparam logic [7:0] ADDR_LOAD_SWITCH = 8'h29;
	localparam logic [7:0] ADDR_OV_THR_A = 8'h2a;
	localparam logic [7:0] ADDR_OV_THR_B = 8'h2b;
	localparam logic [7:0] ADDR_OV_FLAGS = 8'h2c;
	localparam logic [15:0] RST_BUCK2 = 16'h088a;
	localparam logic [15:0] RST_BUCK3 = 16'h8b8a;
	localparam logic [5:0][15:0] RST_LINEAR =
		{16'h6000, 16'ha000, 16'h4000, 16'h6000, 16'ha000, 16'ha000};
	localparam logic [15:0] RST_SWITCHED = 16'hb000;
	localparam logic [15:0] RST_LOAD_SWITCH = 16'h0000;
	localparam logic [15:0] RST_OV_THR_A = 16'h5555;
	localparam logic [15:0] RST_OV_THR_B = 16'h5550;
	localparam logic [15:0] RST_OV_FLAGS = 16'h0000;

	// ***************************************************
	// Field positions
	// ***************************************************
	localparam int BUCK_PFM_LIMIT = 0;
	localparam int BUCK_LEVEL_LO = 1;
	localparam int BUCK_DETECT_EN = 3;
	localparam int BUCK_PEAK_THR = 4;
	localparam int BUCK_AUTO_EN = 5;
	localparam int BUCK_FORCED_MOD = 6;
	localparam int STAGE3_SELECT = 7;
	localparam int STAGE3_OVERRIDE = 8;
	localparam int BUCK3_VOLT_LO = 9;
	localparam int BUCK3_PULLDOWN = 12;
	localparam int LIN_VOLT_LO = 13;
	localparam int LIN_SOFT = 12;
	localparam int LIN_BIAS = 11;
	localparam int LIN6_VOLT_LO = 11;
	localparam int LIN6_SOFT = 10;
	localparam int LIN6_BIAS = 9;
	localparam int SWITCHED_LOWV_EN = 12;
	localparam int LSW_ON_N = 15;
	localparam int LSW_MODE = 5;
	localparam int LSW_VOLT_LO = 3;
	localparam int LSW_DISCHARGE = 1;
	localparam int LSW_BIAS = 0;
	localparam int FLAGS_CLEAR = 0;
	localparam logic [15:0] FLAGS_MASK = 16'hfff0;
	// Channels: buck1..3, linear1,2,3,5,6,7; flag bit and trip field
	localparam int OV_CHANNELS = 9;
	localparam logic [8:0][3:0] OV_FLAG_POS = {4'h5, 4'h6, 4'h7, 4'h9,
		4'ha, 4'hb, 4'hd, 4'he, 4'hf};
	localparam logic [8:0][3:0] OV_TRIP_POS = {4'ha, 4'hc, 4'he, 4'h2,
		4'h4, 4'h6, 4'ha, 4'hc, 4'he};
	localparam logic [8:0] OV_TRIP_IN_B = 9'h1c0;

	// ***************************************************
	// Voltages, trip points, levels and timing
	// ***************************************************
	localparam int HV_BASE_MV = 2600;
	localparam int LV_BASE_MV = 1500;
	localparam int STEP3_MV = 100;
	localparam int LV_MAX_CODE = 5;
	localparam int FINE_BASE_MV = 700;
	localparam int FINE_STEP_MV = 25;
	localparam int FINE_MAX_CODE = 28;
	localparam int LSW_BASE_MV = 3000;
	localparam logic [3:0][4:0] TRIP_BUCK = {5'h14, 5'h14, 5'h14, 5'h0a};
	localparam logic [3:0][4:0] TRIP_LIN1 = {5'h14, 5'h0f, 5'h0b, 5'h07};
	localparam logic [3:0][4:0] TRIP_LIN = {5'h14, 5'h0f, 5'h0a, 5'h05};
	localparam logic [10:0] BUCK2_FIXED_MA = 11'h4e2;
	localparam logic [10:0] BUCK3_FIXED_MA = 11'h532;
	localparam logic [1:0] LEVEL_FIXED = 2'h1;
	localparam int CLK_MHZ = 125;
	localparam int OV_PERSIST_US = 1000;
	localparam int OV_PERSIST_CYCLES = OV_PERSIST_US * CLK_MHZ;

	// ***************************************************
	// Carrier types
	// ***************************************************
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [15:0] wdata;
	} rgc_req_type;

	typedef struct packed {
		logic auto_en;
		logic pwm_mode;
		logic detect_en;
		logic [1:0] detect_level;
		logic [10:0] fixed_level_ma;
		logic pfm_limit_big;
		logic peak_thr_big;
	} rgc_buck_type;

	typedef struct packed {
		logic [11:0] voltage_mv;
		logic bias_big;
		logic soft_slow;
	} rgc_linear_type;

	typedef struct packed {
		logic on;
		logic switch_mode;
		logic [11:0] voltage_mv;
		logic discharge_en;
		logic bias_big;
	} rgc_lsw_type;

	// Three-bit code to millivolts, high or low range
	function automatic logic [11:0] rgc_code3_mv(logic [2:0] code,
		logic low_range);
		int c;
		c = int'(code);
		if (low_range) begin
			if (c > LV_MAX_CODE) begin
				c = LV_MAX_CODE;
			end
			return 12'(LV_BASE_MV + STEP3_MV * c);
		end
		return 12'(HV_BASE_MV + STEP3_MV * c);
	endfunction : rgc_code3_mv

	// Five-bit fine code saturating at code 28 (1400mV)
	function automatic logic [11:0] rgc_fine_mv(logic [4:0] code);
		int c;
		c = int'(code);
		if (c > FINE_MAX_CODE) begin
			c = FINE_MAX_CODE;
		end
		return 12'(FINE_BASE_MV + FINE_STEP_MV * c);
	endfunction : rgc_fine_mv

endpackage : rgc_pkg

// file: design/rgc_sync2.sv
// Two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
module rgc_sync2 #(
	parameter int WIDTH = 9
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [WIDTH-1:0] d_async,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	// First stage feeds only the second stage
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			meta <= '0;
			q <= '0;
		end else if (ce) begin
			meta <= d_async;
			q <= meta;
		end
	end
endmodule : rgc_sync2

// file: design/rgc_ov_persist.sv
// Persistence qualifier: level must hold COUNT cycles unbroken
`timescale 1ns/1ps
module rgc_ov_persist #(
	parameter int COUNT = 125000
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic level,
	output logic qualified
);
	localparam int CW = $clog2(COUNT + 1);
	localparam logic [CW-1:0] LAST = CW'(COUNT - 1);
	logic [CW-1:0] cnt;

	// Any drop restarts the window, so glitches never accumulate
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cnt <= '0;
			qualified <= 1'b0;
		end else if (ce) begin
			if (!level) begin
				cnt <= '0;
				qualified <= 1'b0;
			end else if (cnt == LAST) begin
				qualified <= 1'b1;
			end else begin
				cnt <= cnt + 1'b1;
			end
		end
	end

	// Qualification never comes before the full window
	a_persist_window: assert property (
		@(posedge ref_clk) disable iff (rst)
		$rose(qualified) |-> $past(cnt) == LAST && $past(level))
		else $error("overvoltage qualified before full window");
endmodule : rgc_ov_persist

// file: design/rgc_regulator_regs.sv
// Regulator control and overvoltage register bank
`timescale 1ns/1ps
module rgc_regulator_regs
	import rgc_pkg::*;
#(
	parameter int OV_PERSIST = OV_PERSIST_CYCLES,
	parameter bit LATE_SILICON = 1'b1
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	input wire rgc_req_type reg_req,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic [8:0] ov_raw,
	input wire logic [8:0] ov_int_enable,
	output logic [8:0] ov_irq,
	output logic [8:0][4:0] ov_trip_pct,
	output rgc_buck_type buck2_ctl,
	output rgc_buck_type buck3_ctl,
	output logic [11:0] buck3_voltage_mv,
	output logic stage3_linear_mode,
	output logic buck3_output_pulldown,
	output rgc_linear_type [5:0] linear_ctl,
	output logic [11:0] switched_supply_mv,
	output logic switched_supply_lowv_protect_en,
	output rgc_lsw_type load_switch
);
	// ***************************************************
	// Register storage
	// ***************************************************
	logic [15:0] buck2_control;
	logic [15:0] buck3_control;
	logic [5:0][15:0] linear_control;
	logic [15:0] switched_supply_control;
	logic [15:0] load_switch_control;
	logic [15:0] overvoltage_threshold_a;
	logic [15:0] overvoltage_threshold_b;
	logic [15:0] ov_flags;
	logic ov_flags_clear;
	logic [8:0] ov_level;
	logic [8:0] ov_qual;
	logic [8:0] ov_qual_d;
	logic [8:0] ov_event;
	logic [15:0] next_ov_flags;
	logic clear_write;

	assign clear_write = reg_req.wr && reg_req.addr == ADDR_OV_FLAGS &&
		reg_req.wdata[FLAGS_CLEAR];

	// Host writes, if/else-if address decode
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			buck2_control <= RST_BUCK2;
			buck3_control <= RST_BUCK3;
			linear_control <= RST_LINEAR;
			switched_supply_control <= RST_SWITCHED;
			load_switch_control <= RST_LOAD_SWITCH;
			overvoltage_threshold_a <= RST_OV_THR_A;
			overvoltage_threshold_b <= RST_OV_THR_B;
		end else if (ce && reg_req.wr) begin
			if (reg_req.addr == ADDR_BUCK2) begin
				buck2_control <= reg_req.wdata;
			end else if (reg_req.addr == ADDR_BUCK3) begin
				buck3_control <= reg_req.wdata;
			end else if (reg_req.addr == ADDR_SWITCHED) begin
				switched_supply_control <= reg_req.wdata;
			end else if (reg_req.addr == ADDR_LOAD_SWITCH) begin
				load_switch_control <= reg_req.wdata;
			end else if (reg_req.addr == ADDR_OV_THR_A) begin
				overvoltage_threshold_a <= reg_req.wdata;
			end else if (reg_req.addr == ADDR_OV_THR_B) begin
				overvoltage_threshold_b <= reg_req.wdata;
			end else begin
				for (int i = 0; i < 6; i++) begin
					if (reg_req.addr == ADDR_LINEAR[i]) begin
						linear_control[i] <= reg_req.wdata;
					end
				end
			end
		end
	end

	// ***************************************************
	// Overvoltage detection and flags
	// ***************************************************
	rgc_sync2 #(
		.WIDTH(OV_CHANNELS)
	) u_ov_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.ce(ce),
		.d_async(ov_raw),
		.q(ov_level)
	);

	for (genvar g = 0; g < OV_CHANNELS; g++) begin : g_persist
		rgc_ov_persist #(
			.COUNT(OV_PERSIST)
		) u_persist (
			.ref_clk(ref_clk),
			.rst(rst),
			.ce(ce),
			.level(ov_level[g]),
			.qualified(ov_qual[g])
		);
	end

	assign ov_event = ov_qual & ~ov_qual_d;

	// Flag update: a fresh event beats a clear in the same cycle
	always_comb begin
		next_ov_flags = ov_flags;
		if (clear_write) begin
			next_ov_flags = ov_flags & ~FLAGS_MASK;
		end
		for (int i = 0; i < OV_CHANNELS; i++) begin
			if (ov_event[i]) begin
				next_ov_flags[OV_FLAG_POS[i]] = 1'b1;
			end
		end
	end

	// Latched flags, self-returning clear bit, interrupt pulses
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ov_flags <= RST_OV_FLAGS;
			ov_flags_clear <= 1'b0;
			ov_qual_d <= '0;
			ov_irq <= '0;
		end else if (ce) begin
			ov_flags <= next_ov_flags;
			ov_flags_clear <= clear_write;
			ov_qual_d <= ov_qual;
			ov_irq <= ov_event & ov_int_enable;
		end
	end

	// Read port: one cycle latency, unmapped offsets read zero
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			reg_rdata <= '0;
			reg_rvalid <= 1'b0;
		end else if (ce) begin
			reg_rvalid <= reg_req.rd;
			if (!reg_req.rd) begin
				reg_rdata <= reg_rdata;
			end else if (reg_req.addr == ADDR_BUCK2) begin
				reg_rdata <= buck2_control;
			end else if (reg_req.addr == ADDR_BUCK3) begin
				reg_rdata <= buck3_control;
			end else if (reg_req.addr == ADDR_SWITCHED) begin
				reg_rdata <= switched_supply_control;
			end else if (reg_req.addr == ADDR_LOAD_SWITCH) begin
				reg_rdata <= load_switch_control;
			end else if (reg_req.addr == ADDR_OV_THR_A) begin
				reg_rdata <= overvoltage_threshold_a;
			end else if (reg_req.addr == ADDR_OV_THR_B) begin
				reg_rdata <= overvoltage_threshold_b;
			end else if (reg_req.addr == ADDR_OV_FLAGS) begin
				reg_rdata <= ov_flags | 16'(ov_flags_clear);
			end else begin
				reg_rdata <= '0;
				for (int i = 0; i < 6; i++) begin
					if (reg_req.addr == ADDR_LINEAR[i]) begin
						reg_rdata <= linear_control[i];
					end
				end
			end
		end
	end

	// ***************************************************
	// Decoded controls toward the analog side
	// ***************************************************
	// Converter controls; buck3 pull-down absent on early silicon
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			buck2_ctl <= '0;
			buck3_ctl <= '0;
			buck3_voltage_mv <= '0;
			stage3_linear_mode <= 1'b1;
			buck3_output_pulldown <= 1'b0;
		end else if (ce) begin
			buck2_ctl.auto_en <= buck2_control[BUCK_AUTO_EN];
			buck2_ctl.pwm_mode <= buck2_control[BUCK_FORCED_MOD];
			buck2_ctl.detect_en <= buck2_control[BUCK_DETECT_EN];
			buck2_ctl.detect_level <= buck2_control[BUCK_LEVEL_LO +: 2];
			buck2_ctl.fixed_level_ma <= (buck2_control[BUCK_LEVEL_LO +: 2]
				== LEVEL_FIXED) ? BUCK2_FIXED_MA : '0;
			buck2_ctl.pfm_limit_big <= buck2_control[BUCK_PFM_LIMIT];
			buck2_ctl.peak_thr_big <= buck2_control[BUCK_PEAK_THR];
			buck3_ctl.auto_en <= buck3_control[BUCK_AUTO_EN];
			buck3_ctl.pwm_mode <= buck3_control[BUCK_FORCED_MOD];
			buck3_ctl.detect_en <= buck3_control[BUCK_DETECT_EN];
			buck3_ctl.detect_level <= buck3_control[BUCK_LEVEL_LO +: 2];
			buck3_ctl.fixed_level_ma <= (buck3_control[BUCK_LEVEL_LO +: 2]
				== LEVEL_FIXED) ? BUCK3_FIXED_MA : '0;
			buck3_ctl.pfm_limit_big <= buck3_control[BUCK_PFM_LIMIT];
			buck3_ctl.peak_thr_big <= buck3_control[BUCK_PEAK_THR];
			buck3_voltage_mv <= rgc_code3_mv(
				buck3_control[BUCK3_VOLT_LO +: 3], 1'b0);
			stage3_linear_mode <= buck3_control[STAGE3_OVERRIDE] ||
				!buck3_control[STAGE3_SELECT];
			buck3_output_pulldown <= LATE_SILICON &&
				buck3_control[BUCK3_PULLDOWN];
		end
	end

	// Linear regulators; index 4 is the fine-step one
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			linear_ctl <= '0;
			switched_supply_mv <= '0;
			switched_supply_lowv_protect_en <= 1'b1;
		end else if (ce) begin
			for (int i = 0; i < 6; i++) begin
				if (i == 4) begin
					linear_ctl[i].voltage_mv <= rgc_fine_mv(
						linear_control[i][LIN6_VOLT_LO +: 5]);
					linear_ctl[i].bias_big <= linear_control[i][LIN6_BIAS];
					linear_ctl[i].soft_slow <= linear_control[i][LIN6_SOFT];
				end else begin
					linear_ctl[i].voltage_mv <= rgc_code3_mv(
						linear_control[i][LIN_VOLT_LO +: 3],
						i == 2 || i == 5);
					linear_ctl[i].bias_big <= linear_control[i][LIN_BIAS];
					linear_ctl[i].soft_slow <= linear_control[i][LIN_SOFT];
				end
			end
			switched_supply_mv <= rgc_code3_mv(
				switched_supply_control[LIN_VOLT_LO +: 3], 1'b0);
			switched_supply_lowv_protect_en <=
				switched_supply_control[SWITCHED_LOWV_EN];
		end
	end

	// Load switch; discharge exclusivity is left to software
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			load_switch <= '0;
		end else if (ce) begin
			load_switch.on <= !load_switch_control[LSW_ON_N];
			load_switch.switch_mode <= load_switch_control[LSW_MODE];
			load_switch.voltage_mv <= 12'(LSW_BASE_MV + STEP3_MV *
				int'(load_switch_control[LSW_VOLT_LO +: 2]));
			load_switch.discharge_en <= load_switch_control[LSW_DISCHARGE];
			load_switch.bias_big <= load_switch_control[LSW_BIAS];
		end
	end

	// Trip points in percent above nominal, per channel
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ov_trip_pct <= '0;
		end else if (ce) begin
			for (int i = 0; i < OV_CHANNELS; i++) begin
				if (i < 3) begin
					ov_trip_pct[i] <= TRIP_BUCK[{1'b0,
						overvoltage_threshold_a[OV_TRIP_POS[i]]}];
				end else if (i == 3) begin
					ov_trip_pct[i] <= TRIP_LIN1[
						overvoltage_threshold_a[OV_TRIP_POS[i] +: 2]];
				end else if (OV_TRIP_IN_B[i]) begin
					ov_trip_pct[i] <= TRIP_LIN[
						overvoltage_threshold_b[OV_TRIP_POS[i] +: 2]];
				end else begin
					ov_trip_pct[i] <= TRIP_LIN[
						overvoltage_threshold_a[OV_TRIP_POS[i] +: 2]];
				end
			end
		end
	end

	// ***************************************************
	// Assertions
	// ***************************************************
	sequence s_live;
		!$past(rst) && $past(ce);
	endsequence

	a_stage3_select: assert property (
		@(posedge ref_clk) disable iff (rst)
		s_live |-> stage3_linear_mode == ($past(buck3_control[8]) ||
		!$past(buck3_control[7])))
		else $error("stage3 circuit selection wrong");
	a_buck3_forced: assert property (
		@(posedge ref_clk) disable iff (rst)
		s_live ##0 !buck3_ctl.auto_en |->
		buck3_ctl.pwm_mode == $past(buck3_control[6]))
		else $error("buck3 forced modulation not followed");
	a_linear6_sat: assert property (
		@(posedge ref_clk) disable iff (rst)
		s_live ##0 $past(linear_control[4][15:11]) > 5'h1c |->
		linear_ctl[4].voltage_mv == 12'h578)
		else $error("linear6 code does not saturate at 1400mV");
	a_buck_trip: assert property (
		@(posedge ref_clk) disable iff (rst)
		s_live |-> ov_trip_pct[0] == ($past(overvoltage_threshold_a[14])
		? 5'h14 : 5'h0a))
		else $error("buck1 trip point wrong");
	a_linear1_trip: assert property (
		@(posedge ref_clk) disable iff (rst)
		s_live ##0 $past(overvoltage_threshold_a[7:6]) == 2'h1 |->
		ov_trip_pct[3] == 5'h0b)
		else $error("linear1 trip point wrong");
	a_linear_trip: assert property (
		@(posedge ref_clk) disable iff (rst)
		s_live ##0 $past(overvoltage_threshold_b[15:14]) == 2'h0 |->
		ov_trip_pct[6] == 5'h05)
		else $error("linear5 trip point wrong");
	a_irq_gated: assert property (
		@(posedge ref_clk) disable iff (rst)
		ov_irq[0] |-> $past(ov_int_enable[0]) && ov_flags[15])
		else $error("interrupt without enable or flag");
	a_flags_clear: assert property (
		@(posedge ref_clk) disable iff (rst)
		ce && clear_write && ov_event == '0 |=>
		(ov_flags & FLAGS_MASK) == '0 ##1 !ov_flags_clear)
		else $error("flag clear did not take effect or return");
	a_switch_on: assert property (
		@(posedge ref_clk) disable iff (rst)
		s_live |-> load_switch.on == !$past(load_switch_control[15]))
		else $error("load switch enable polarity wrong");
endmodule : rgc_regulator_regs

// file: testbench/rgc_host_model.sv
// Host-side model issuing register requests on the block's clock
`timescale 1ns/1ps
module rgc_host_model
	import rgc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_rvalid,
	output rgc_req_type reg_req
);

	// ***************************************************
	// Bus idle and release
	// ***************************************************
	// Idle bus starts quiet
	initial begin
		reg_req = '0;
	end

	// Scramble address and data so a stale value never looks valid
	task automatic release_bus();
		reg_req.wr = 1'b0;
		reg_req.rd = 1'b0;
		reg_req.addr = ~reg_req.addr;
		reg_req.wdata = ~reg_req.wdata;
	endtask : release_bus

	// ***************************************************
	// Register access
	// ***************************************************
	// One-cycle write; discharge never rides with bit2 or bit15
	task automatic write_reg(input logic [7:0] addr,
		input logic [15:0] data);
		logic [15:0] d;
		d = data;
		if (addr == ADDR_LOAD_SWITCH && d[1] && (d[2] || d[15])) begin
			d[1] = 1'b0;
		end
		@(posedge ref_clk);
		#1;
		reg_req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: d};
		@(posedge ref_clk);
		#1;
		release_bus();
	endtask : write_reg

	// One-cycle read; data arrives with the valid pulse
	task automatic read_reg(input logic [7:0] addr,
		output logic [15:0] data);
		@(posedge ref_clk);
		#1;
		reg_req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 16'h0000};
		@(posedge ref_clk);
		#1;
		data = (reg_rvalid === 1'b1) ? reg_rdata : 16'hxxxx;
		release_bus();
	endtask : read_reg

endmodule : rgc_host_model

// file: testbench/rgc_regulator_regs_test.sv
// Self-checking testbench for the regulator control register bank
`timescale 1ns/1ps
module rgc_regulator_regs_test
	import rgc_pkg::*;
;

	// ***************************************************
	// Signals and bookkeeping
	// ***************************************************
	localparam int PERSIST = 8;
	logic ref_clk;
	logic rst;
	logic ce;
	rgc_req_type reg_req;
	logic [15:0] reg_rdata;
	logic reg_rvalid;
	logic [8:0] ov_raw;
	logic [8:0] ov_int_enable;
	logic [8:0] ov_irq;
	logic [8:0][4:0] ov_trip_pct;
	rgc_buck_type buck2_ctl;
	rgc_buck_type buck3_ctl;
	logic [11:0] buck3_voltage_mv;
	logic stage3_linear_mode;
	logic buck3_output_pulldown;
	rgc_linear_type [5:0] linear_ctl;
	logic [11:0] switched_supply_mv;
	logic switched_supply_lowv_protect_en;
	rgc_lsw_type load_switch;
	int error_cnt;
	int comparisons;
	int irq_cnt [9] = '{default: 0};
	int n;
	logic [15:0] rdv;
	logic [15:0] d;
	logic [15:0] seen;
	logic [15:0] exp_v;
	logic [2:0] b;
	logic [4:0] c5;
	logic [7:0] raddr [12] = '{8'h17, 8'h1e, 8'h1f, 8'h20, 8'h22, 8'h23,
		8'h24, 8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2c};
	logic [15:0] rval [12] = '{16'h8b8a, 16'ha000, 16'ha000, 16'h6000,
		16'h4000, 16'ha000, 16'h6000, 16'hb000, 16'h0000, 16'h5555,
		16'h5550, 16'h0000};
	int lin1_pct [4] = '{7, 11, 15, 20};
	int lin_pct [4] = '{5, 10, 15, 20};

	// ***************************************************
	// Design, host and clock
	// ***************************************************
	rgc_regulator_regs #(.OV_PERSIST(PERSIST), .LATE_SILICON(1'b1)) u_dut (
		.ref_clk(ref_clk), .rst(rst), .ce(ce), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .ov_raw(ov_raw),
		.ov_int_enable(ov_int_enable), .ov_irq(ov_irq),
		.ov_trip_pct(ov_trip_pct), .buck2_ctl(buck2_ctl),
		.buck3_ctl(buck3_ctl), .buck3_voltage_mv(buck3_voltage_mv),
		.stage3_linear_mode(stage3_linear_mode),
		.buck3_output_pulldown(buck3_output_pulldown),
		.linear_ctl(linear_ctl), .switched_supply_mv(switched_supply_mv),
		.switched_supply_lowv_protect_en(switched_supply_lowv_protect_en),
		.load_switch(load_switch));

	rgc_host_model u_host (.ref_clk(ref_clk), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .reg_req(reg_req));

	// Free-running 125 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	// Count interrupt pulses mid-cycle, away from the launching edge
	always @(negedge ref_clk) begin
		for (int k = 0; k < 9; k++) begin
			if (ov_irq[k] === 1'b1) begin
				irq_cnt[k]++;
			end
		end
	end

	// ***************************************************
	// Helpers
	// ***************************************************
	task automatic check(input logic [15:0] s, input logic [15:0] e);
		comparisons++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %0t seen %h expected %h", $time, s, e);
		end
	endtask : check

	task automatic tick(input int cycles);
		repeat (cycles) @(posedge ref_clk);
		#1;
	endtask : tick

	// Trip percentages for a buck code and a common linear code
	task automatic trips(input logic bc, input logic [1:0] lc);
		for (int k = 0; k < 3; k++) begin
			check(16'(ov_trip_pct[k]), bc ? 16'h0014 : 16'h000a);
		end
		check(16'(ov_trip_pct[3]), 16'(lin1_pct[lc]));
		for (int k = 4; k < 9; k++) begin
			check(16'(ov_trip_pct[k]), 16'(lin_pct[lc]));
		end
	endtask : trips

	task automatic finish_test();
		if (error_cnt == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : finish_test

	// Watchdog far beyond the few hundred cycles the run needs
	initial begin
		#400000;
		error_cnt++;
		finish_test();
	end

	// ***************************************************
	// Test sequence
	// ***************************************************
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		ov_raw = '0;
		ov_int_enable = 9'h1fd;
		error_cnt = 0;
		comparisons = 0;
		repeat (5) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		tick(2);
		// Reset values of the map except buck2, and their decoded effects
		for (int k = 0; k < 12; k++) begin
			u_host.read_reg(raddr[k], rdv);
			check(rdv, rval[k]);
		end
		check(16'(load_switch.on), 16'h0001);
		check(16'(buck3_ctl.detect_en), 16'h0001);
		check(16'(switched_supply_lowv_protect_en), 16'h0001);
		trips(1'b1, 2'b01);
		// Buck2 fixed detect level
		u_host.write_reg(ADDR_BUCK2, 16'h0002);
		tick(1);
		check(16'(buck2_ctl.fixed_level_ma), 16'h04e2);
		// Buck3 mode, selection, pull-down, current and voltage fields
		for (int i = 0; i < 8; i++) begin
			b = 3'(i);
			d = {3'b000, b[0], b, b[2], b[1], b[0], 1'b0, b[1], b[2],
				b[1:0], b[0]};
			u_host.write_reg(ADDR_BUCK3, d);
			tick(1);
			seen = 16'({buck3_ctl.auto_en, buck3_ctl.pwm_mode,
				stage3_linear_mode, buck3_output_pulldown});
			exp_v = 16'({1'b0, b[0], b[2] | ~b[1], b[0]});
			check(seen, exp_v);
			seen = 16'({buck3_ctl.pfm_limit_big, buck3_ctl.peak_thr_big,
				buck3_ctl.detect_en, buck3_ctl.detect_level});
			check(seen, 16'({b[0], b[1], b[2], b[1:0]}));
			exp_v = (b[1:0] == 2'b01) ? 16'h0532 : 16'h0000;
			check(16'(buck3_ctl.fixed_level_ma), exp_v);
			check(16'(buck3_voltage_mv), 16'(2600 + 100 * i));
		end
		// Linear regulators: voltage codes, bias and soft start
		for (int k = 0; k < 6; k++) begin
			for (int i = 0; i < 8; i++) begin
				b = 3'(i);
				c5 = 5'(i * 4 + ((i == 7) ? 3 : 0));
				d = (k == 4) ? {c5, b[0], b[1], 9'h000}
					: {b, b[0], b[1], 11'h000};
				u_host.write_reg(ADDR_LINEAR[k], d);
				u_host.read_reg(ADDR_LINEAR[k], rdv);
				check(rdv, d);
				if (k == 4) begin
					n = 700 + 25 * ((c5 > 28) ? 28 : int'(c5));
				end else if (k == 2 || k == 5) begin
					n = 1500 + 100 * ((i > 5) ? 5 : i);
				end else begin
					n = 2600 + 100 * i;
				end
				check(16'(linear_ctl[k].voltage_mv), 16'(n));
				seen = 16'({linear_ctl[k].soft_slow, linear_ctl[k].bias_big});
				check(seen, 16'({b[0], b[1]}));
			end
		end
		// Switched supply protection off, top voltage code
		u_host.write_reg(ADDR_SWITCHED, 16'he000);
		tick(1);
		check(16'(switched_supply_lowv_protect_en), 16'h0000);
		check(16'(switched_supply_mv), 16'h0ce4);
		// Enable low freezes state, so this write must never land
		ce = 1'b0;
		u_host.write_reg(ADDR_SWITCHED, 16'h1000);
		ce = 1'b1;
		tick(1);
		check(16'(switched_supply_lowv_protect_en), 16'h0000);
		check(16'(switched_supply_mv), 16'h0ce4);
		// Load switch modes, voltages, active-low enable, discharge
		for (int j = 0; j < 4; j++) begin
			b = 3'(j);
			d = {b[1], 9'h000, b[0], b[1:0], 1'b0, ~b[1], b[0]};
			u_host.write_reg(ADDR_LOAD_SWITCH, d);
			tick(1);
			seen = 16'({load_switch.on, load_switch.switch_mode,
				load_switch.discharge_en, load_switch.bias_big});
			check(seen, 16'({~b[1], b[0], ~b[1], b[0]}));
			if (!b[0]) begin
				check(16'(load_switch.voltage_mv), 16'(3000 + 100 * j));
			end
		end
		u_host.write_reg(ADDR_LOAD_SWITCH, 16'h8002);
		tick(1);
		check(16'(load_switch.discharge_en), 16'h0000);
		// Every trip code on every channel
		for (int i = 0; i < 4; i++) begin
			b = 3'(i);
			d = {1'b0, b[0], 1'b0, b[0], 1'b0, b[0], 2'b00, b[1:0], b[1:0],
				b[1:0], 2'b00};
			u_host.write_reg(ADDR_OV_THR_A, d);
			u_host.write_reg(ADDR_OV_THR_B, {b[1:0], b[1:0], b[1:0], 10'h000});
			tick(1);
			trips(b[0], b[1:0]);
		end
		// Unmapped offset ignores writes and reads zero
		u_host.write_reg(8'h15, 16'hffff);
		u_host.read_reg(8'h15, rdv);
		check(rdv, 16'h0000);
		// Short overvoltage glitch must not qualify
		ov_raw[2] = 1'b1;
		tick(PERSIST - 2);
		ov_raw[2] = 1'b0;
		// Sustained overvoltage on buck1 and buck2, buck2 irq disabled
		ov_raw[1:0] = 2'b11;
		n = 0;
		while (irq_cnt[0] == 0 && n < 40) begin
			tick(1);
			n++;
		end
		check(16'(n >= PERSIST && n <= PERSIST + 4), 16'h0001);
		tick(4);
		ov_raw = '0;
		tick(4);
		check(16'(irq_cnt[0]), 16'h0001);
		check(16'(irq_cnt[1]), 16'h0000);
		check(16'(irq_cnt[2]), 16'h0000);
		u_host.read_reg(ADDR_OV_FLAGS, rdv);
		check(rdv, 16'hc000);
		// Flags are read-only; only the clear bit wipes them
		u_host.write_reg(ADDR_OV_FLAGS, 16'hfff0);
		u_host.read_reg(ADDR_OV_FLAGS, rdv);
		check(rdv, 16'hc000);
		u_host.write_reg(ADDR_OV_FLAGS, 16'h0001);
		tick(2);
		u_host.read_reg(ADDR_OV_FLAGS, rdv);
		check(rdv, 16'h0000);
		finish_test();
	end

endmodule : rgc_regulator_regs_test
